/* File: hw/dsa_pkg.sv */
// Purpose: Shared types and constants for the data space access unit.
// Assumes: 10 MHz core clock, 8-bit data path, 16-bit data addresses.
// Notes:   Map locations of the demo registers are fixed here only.
package dsa_pkg;

    localparam int          CLK_PERIOD_NS     = 100;
    localparam int          NV_WRITE_TIME_NS  = 3_400_000;
    localparam int          SRAM_DEPTH_DEF    = 1024;
    localparam int          NUM_WREGS         = 32;
    localparam int          NUM_GS            = 3;

    localparam logic [15:0] IO_BASE           = 16'h0020;
    localparam logic [15:0] EXT_BASE          = 16'h0060;
    localparam logic [15:0] SRAM_BASE         = 16'h0100;
    localparam logic [5:0]  IO_BIT_LIMIT      = 6'h20;

    localparam logic [15:0] GS0_ADDR          = 16'h003E;
    localparam logic [15:0] GS1_ADDR          = 16'h004A;
    localparam logic [15:0] GS2_ADDR          = 16'h004B;
    localparam logic [15:0] FLAG_ADDR         = 16'h0035;
    localparam logic [15:0] WORD_LO_ADDR      = 16'h0084;
    localparam logic [15:0] WORD_HI_ADDR      = 16'h0085;
    localparam logic [15:0] TEMP_ADDR         = 16'h0086;

    localparam logic [4:0]  PTR_X_LO          = 5'h1A;
    localparam logic [4:0]  PTR_Y_LO          = 5'h1C;
    localparam logic [4:0]  PTR_Z_LO          = 5'h1E;

    localparam logic [2:0]  SRAM_WAIT         = 3'h1;
    localparam logic [2:0]  NV_READ_HALT      = 3'h4;
    localparam logic [2:0]  NV_WRITE_HALT     = 3'h2;
    localparam logic [7:0]  BYTE_RESET        = 8'h00;

    typedef enum logic [3:0] {
        OP_LOAD                 = 4'h0,
        OP_STORE                = 4'h1,
        OP_IN                   = 4'h2,
        OP_OUT                  = 4'h3,
        OP_IO_BIT_SET           = 4'h4,
        OP_IO_BIT_CLEAR         = 4'h5,
        OP_SKIP_IF_IO_BIT_SET   = 4'h6,
        OP_SKIP_IF_IO_BIT_CLEAR = 4'h7,
        OP_NV_READ              = 4'h8,
        OP_NV_WRITE             = 4'h9
    } op_t;

    typedef enum logic [2:0] {
        MODE_DIRECT    = 3'h0,
        MODE_DISPLACED = 3'h1,
        MODE_INDIRECT  = 3'h2,
        MODE_PRE_DEC   = 3'h3,
        MODE_POST_INC  = 3'h4
    } mode_t;

    typedef enum logic [1:0] {
        PTR_X = 2'h0,
        PTR_Y = 2'h1,
        PTR_Z = 2'h2
    } ptr_t;

    typedef enum logic [1:0] {
        WAIT_SRAM     = 2'h0,
        WAIT_NV_READ  = 2'h1,
        WAIT_NV_WRITE = 2'h2
    } wait_kind_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_WAIT = 1'b1
    } state_t;

    typedef struct packed {
        logic        valid;
        op_t         op;
        mode_t       mode;
        ptr_t        ptr;
        logic [15:0] addr;
        logic [5:0]  disp;
        logic [2:0]  bit_sel;
        logic [7:0]  wdata;
    } req_t;

    typedef struct packed {
        logic        done;
        logic        skip;
        logic [7:0]  rdata;
    } ans_t;

    typedef struct packed {
        logic        strobe;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } nv_cmd_t;

endpackage

/* File: hw/dsa_sram.sv */
// Purpose: Single-port byte memory for the internal data SRAM.
// Assumes: One access per cycle, read data registered.
// Notes:   Read data holds until the next read enable.
`timescale 1ns/1ps
module dsa_sram #(
    parameter int DEPTH = 1024,
    parameter int AW    = 10
) (
    input  wire logic          clk_in,    // Core clock
    input  wire logic          we_in,     // Write strobe
    input  wire logic          re_in,     // Read strobe
    input  wire logic [AW-1:0] addr_in,   // Byte index
    input  wire logic [7:0]    wdata_in,  // Write byte
    output logic      [7:0]    rdata_out  // Registered read byte
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        if (re_in) begin
            rdata_out <= mem[addr_in];
        end
    end
endmodule

/* File: hw/data_space_access_unit.sv */
// Purpose: Data space decoder, I/O access and stall control for the core.
// Assumes: Core presents req_in valid for one cycle; one request at a time.
// Notes:   Nonvolatile array lives outside; only commands leave here.
// Behaviour
// [R1] Decode registers, I/O, extended I/O, then SRAM
// [R2] Extended I/O reachable only by load/store
// [R3] Direct addressing reaches the whole data space
// [R4] Displaced address is Y or Z plus 0..63
// [R5] Registers 26..31 form three pointer pairs
// [R6] Pre-decrement before, post-increment after, written back
// [R7] SRAM access takes two clock cycles
// [R8] Nonvolatile read halts four, write halts two
// [R9] Reset does not abort a nonvolatile write
// [R10] I/O address plus 0x20 gives data address
// [R11] Single-bit writes only for I/O 0x00-0x1F
// [R12] Bit tests skip on set or clear
// [R13] Bit set or clear touches one bit only
// [R14] Status flags clear on one, keep on zero
// [R15] Software writes reserved bits as zero
// [R16] Three general storage registers, low one bit-accessible
// [R17] Software writes low byte before high byte
// [R18] Low write to temp; high write commits both
// [R19] Low read captures high; high read returns capture
// [R20] Software reads low byte before high byte
// [R21] Temporary byte directly readable and writable
// [R22] Software may mask interrupts around word access
// [R23] Unmapped writes ignored, unmapped reads give zero
`timescale 1ns/1ps
module data_space_access_unit #(
    parameter int SRAM_DEPTH      = dsa_pkg::SRAM_DEPTH_DEF,
    parameter int NV_WRITE_CYCLES =
        dsa_pkg::NV_WRITE_TIME_NS / dsa_pkg::CLK_PERIOD_NS
) (
    input  wire logic          clk_in,            // Core clock
    input  wire logic          sys_rst_in,        // Sync reset, high
    input  wire dsa_pkg::req_t req_in,            // Core access request
    input  wire logic [7:0]    flag_event_in,     // Status flag set pulses
    input  wire logic [7:0]    nv_rdata_in,       // Nonvolatile read byte
    output dsa_pkg::ans_t      ans_out,           // Access answer
    output logic               busy_out,          // Core halt
    output dsa_pkg::nv_cmd_t   nv_cmd_out,        // Nonvolatile command
    output logic               nv_write_busy_out  // Nonvolatile write active
);
    localparam int AW = $clog2(SRAM_DEPTH);
    localparam int NW = $clog2(NV_WRITE_CYCLES + 1);

    logic [7:0]          rf_reg [dsa_pkg::NUM_WREGS];
    logic [7:0]          rf_next [dsa_pkg::NUM_WREGS];
    logic [7:0]          gs_reg [dsa_pkg::NUM_GS];
    logic [7:0]          gs_next [dsa_pkg::NUM_GS];
    logic [7:0]          flag_reg, flag_next;
    logic [15:0]         word_reg, word_next;
    logic [7:0]          temp_reg, temp_next;
    dsa_pkg::state_t     state_reg, state_next;
    dsa_pkg::wait_kind_t kind_reg, kind_next;
    logic [2:0]          cnt_reg, cnt_next;
    dsa_pkg::ans_t       ans_reg, ans_next;
    dsa_pkg::nv_cmd_t    nv_cmd_reg, nv_cmd_next;
    logic                busy_reg;
    logic [NW-1:0]       nv_cnt_reg, nv_cnt_next;
    logic                nv_busy_reg;

    logic [4:0]  pidx;
    logic [15:0] base, eff, new_ptr;
    logic        accept, is_io, is_bit, is_skip, bit_ok, in_sram, is_read;
    logic        wr_en, ptr_upd, nv_start;
    logic [7:0]  wr_mask, wr_data, rd_byte, flag_clr, bit_mask;
    logic [7:0]  mem_rdata;

    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [7:0] data,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (data & mask);
    endfunction

    assign accept  = req_in.valid && (state_reg == dsa_pkg::ST_IDLE);
    assign is_io   = req_in.op inside {dsa_pkg::OP_IN, dsa_pkg::OP_OUT,
                     dsa_pkg::OP_IO_BIT_SET, dsa_pkg::OP_IO_BIT_CLEAR,
                     dsa_pkg::OP_SKIP_IF_IO_BIT_SET,
                     dsa_pkg::OP_SKIP_IF_IO_BIT_CLEAR};
    assign is_skip = req_in.op inside {dsa_pkg::OP_SKIP_IF_IO_BIT_SET,
                     dsa_pkg::OP_SKIP_IF_IO_BIT_CLEAR};
    assign is_bit  = is_skip || req_in.op inside {dsa_pkg::OP_IO_BIT_SET,
                     dsa_pkg::OP_IO_BIT_CLEAR};
    assign is_read = req_in.op inside {dsa_pkg::OP_LOAD, dsa_pkg::OP_IN};
    // [R11] bit range check
    assign bit_ok   = req_in.addr[5:0] < dsa_pkg::IO_BIT_LIMIT;
    assign bit_mask = 8'h01 << req_in.bit_sel;

    // Address formation
    always_comb begin
        // [R5] pointer pair select
        unique case (req_in.ptr)
            dsa_pkg::PTR_X: pidx = dsa_pkg::PTR_X_LO;
            dsa_pkg::PTR_Y: pidx = dsa_pkg::PTR_Y_LO;
            default:        pidx = dsa_pkg::PTR_Z_LO;
        endcase
        // [R4] displacement uses Y or Z only
        if (req_in.mode == dsa_pkg::MODE_DISPLACED &&
            req_in.ptr != dsa_pkg::PTR_Y) begin
            pidx = dsa_pkg::PTR_Z_LO;
        end
        base = {rf_reg[5'(pidx + 5'h01)], rf_reg[pidx]};
        // [R3] direct reaches everything
        unique case (req_in.mode)
            dsa_pkg::MODE_DIRECT:    eff = req_in.addr;
            dsa_pkg::MODE_DISPLACED: eff = base + {10'h000, req_in.disp};
            dsa_pkg::MODE_PRE_DEC:   eff = base - 16'h0001;
            default:                 eff = base;
        endcase
        // [R10] [R2] six-bit I/O window lands below extended I/O
        if (is_io) begin
            eff = {10'h000, req_in.addr[5:0]} + dsa_pkg::IO_BASE;
        end
        // [R6] pointer writeback value
        new_ptr = (req_in.mode == dsa_pkg::MODE_PRE_DEC) ?
                  base - 16'h0001 : base + 16'h0001;
        ptr_upd = accept && !is_io &&
                  (req_in.mode inside {dsa_pkg::MODE_PRE_DEC,
                                       dsa_pkg::MODE_POST_INC}) &&
                  (req_in.op inside {dsa_pkg::OP_LOAD, dsa_pkg::OP_STORE});
    end

    // [R1] SRAM sits above the extended I/O block
    assign in_sram = (eff >= dsa_pkg::SRAM_BASE) &&
                     ({16'h0000, eff} <
                      (32'(dsa_pkg::SRAM_BASE) + 32'(SRAM_DEPTH)));

    // Read decode; unmapped locations read as zero
    always_comb begin
        // [R1] [R23] decode order and zero default
        rd_byte = dsa_pkg::BYTE_RESET;
        if (eff < dsa_pkg::IO_BASE) begin
            rd_byte = rf_reg[eff[4:0]];
        end else if (eff == dsa_pkg::GS0_ADDR) begin
            rd_byte = gs_reg[0];
        end else if (eff == dsa_pkg::GS1_ADDR) begin
            rd_byte = gs_reg[1];
        end else if (eff == dsa_pkg::GS2_ADDR) begin
            rd_byte = gs_reg[2];
        end else if (eff == dsa_pkg::FLAG_ADDR) begin
            rd_byte = flag_reg;
        end else if (eff == dsa_pkg::WORD_LO_ADDR) begin
            rd_byte = word_reg[7:0];
        end else if (eff == dsa_pkg::WORD_HI_ADDR ||
                     eff == dsa_pkg::TEMP_ADDR) begin
            // [R19] [R21] high byte comes from the capture
            rd_byte = temp_reg;
        end
    end

    // Write strobe and byte lanes
    always_comb begin
        wr_en   = 1'b0;
        wr_mask = 8'hFF;
        wr_data = req_in.wdata;
        if (accept && req_in.op inside {dsa_pkg::OP_STORE, dsa_pkg::OP_OUT})
        begin
            wr_en = 1'b1;
        end else if (accept && is_bit && !is_skip && bit_ok) begin
            // [R13] single lane write
            wr_en   = 1'b1;
            wr_mask = bit_mask;
            wr_data = (req_in.op == dsa_pkg::OP_IO_BIT_SET) ?
                      bit_mask : dsa_pkg::BYTE_RESET;
        end
    end

    // Storage group
    always_comb begin
        rf_next   = rf_reg;
        gs_next   = gs_reg;
        word_next = word_reg;
        temp_next = temp_reg;
        flag_clr  = dsa_pkg::BYTE_RESET;
        if (wr_en) begin
            if (eff < dsa_pkg::IO_BASE) begin
                rf_next[eff[4:0]] = merge(rf_reg[eff[4:0]], wr_data, wr_mask);
            end else if (eff == dsa_pkg::GS0_ADDR) begin
                // [R16] storage registers hold any value
                gs_next[0] = merge(gs_reg[0], wr_data, wr_mask);
            end else if (eff == dsa_pkg::GS1_ADDR) begin
                gs_next[1] = merge(gs_reg[1], wr_data, wr_mask);
            end else if (eff == dsa_pkg::GS2_ADDR) begin
                gs_next[2] = merge(gs_reg[2], wr_data, wr_mask);
            end else if (eff == dsa_pkg::FLAG_ADDR) begin
                // [R14] a one clears, a zero keeps
                flag_clr = wr_data & wr_mask;
            end else if (eff == dsa_pkg::WORD_LO_ADDR ||
                         eff == dsa_pkg::TEMP_ADDR) begin
                // [R18] [R21] low byte parks in the temp byte
                temp_next = merge(temp_reg, wr_data, wr_mask);
            end else if (eff == dsa_pkg::WORD_HI_ADDR) begin
                // [R18] commit both halves together
                word_next = {merge(word_reg[15:8], wr_data, wr_mask),
                             temp_reg};
            end
        end
        // [R19] low read snapshots the high byte
        if (accept && is_read && eff == dsa_pkg::WORD_LO_ADDR) begin
            temp_next = word_reg[15:8];
        end
        // [R6] pointer pair writeback
        if (ptr_upd) begin
            rf_next[pidx]               = new_ptr[7:0];
            rf_next[5'(pidx + 5'h01)]   = new_ptr[15:8];
        end
        // [R14] a hardware set wins over a same-cycle clear
        flag_next = (flag_reg & ~flag_clr) | flag_event_in;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < dsa_pkg::NUM_WREGS; i++) begin
                rf_reg[i] <= dsa_pkg::BYTE_RESET;
            end
            for (int i = 0; i < dsa_pkg::NUM_GS; i++) begin
                gs_reg[i] <= dsa_pkg::BYTE_RESET;
            end
            flag_reg <= dsa_pkg::BYTE_RESET;
            word_reg <= {dsa_pkg::BYTE_RESET, dsa_pkg::BYTE_RESET};
            temp_reg <= dsa_pkg::BYTE_RESET;
        end else begin
            rf_reg   <= rf_next;
            gs_reg   <= gs_next;
            flag_reg <= flag_next;
            word_reg <= word_next;
            temp_reg <= temp_next;
        end
    end

    // [R7] read data registered in the memory gives the second cycle
    dsa_sram #(
        .DEPTH     (SRAM_DEPTH),
        .AW        (AW)
    ) u_sram (
        .clk_in    (clk_in),
        .we_in     (wr_en && in_sram),
        .re_in     (accept && in_sram && is_read),
        .addr_in   (AW'(eff - dsa_pkg::SRAM_BASE)),
        .wdata_in  (wr_data),
        .rdata_out (mem_rdata)
    );

    // Control group
    assign nv_start = accept && req_in.op == dsa_pkg::OP_NV_WRITE &&
                      nv_cnt_reg == '0;

    always_comb begin
        state_next  = state_reg;
        kind_next   = kind_reg;
        cnt_next    = cnt_reg;
        ans_next    = '0;
        nv_cmd_next = '0;
        unique case (state_reg)
            dsa_pkg::ST_IDLE: begin
                if (accept) begin
                    if (req_in.op == dsa_pkg::OP_NV_READ) begin
                        // [R8] four-cycle halt on read
                        state_next  = dsa_pkg::ST_WAIT;
                        kind_next   = dsa_pkg::WAIT_NV_READ;
                        cnt_next    = dsa_pkg::NV_READ_HALT;
                        nv_cmd_next = {1'b1, 1'b0, req_in.addr,
                                       dsa_pkg::BYTE_RESET};
                    end else if (req_in.op == dsa_pkg::OP_NV_WRITE) begin
                        // [R8] two-cycle halt on write
                        state_next  = dsa_pkg::ST_WAIT;
                        kind_next   = dsa_pkg::WAIT_NV_WRITE;
                        cnt_next    = dsa_pkg::NV_WRITE_HALT;
                        nv_cmd_next = {nv_start, 1'b1, req_in.addr,
                                       req_in.wdata};
                    end else if (in_sram && !is_io) begin
                        // [R7] one wait cycle, answer on the second
                        state_next = dsa_pkg::ST_WAIT;
                        kind_next  = dsa_pkg::WAIT_SRAM;
                        cnt_next   = dsa_pkg::SRAM_WAIT;
                    end else begin
                        ans_next.done  = 1'b1;
                        ans_next.rdata = is_read ? rd_byte :
                                         dsa_pkg::BYTE_RESET;
                        // [R12] skip on bit test result
                        ans_next.skip  = is_skip && bit_ok &&
                            (rd_byte[req_in.bit_sel] ==
                             (req_in.op == dsa_pkg::OP_SKIP_IF_IO_BIT_SET));
                    end
                end
            end
            dsa_pkg::ST_WAIT: begin
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h1) begin
                    state_next    = dsa_pkg::ST_IDLE;
                    ans_next.done = 1'b1;
                    if (kind_reg == dsa_pkg::WAIT_SRAM) begin
                        ans_next.rdata = mem_rdata;
                    end else if (kind_reg == dsa_pkg::WAIT_NV_READ) begin
                        ans_next.rdata = nv_rdata_in;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_reg  <= dsa_pkg::ST_IDLE;
            kind_reg   <= dsa_pkg::WAIT_SRAM;
            cnt_reg    <= 3'h0;
            ans_reg    <= '0;
            nv_cmd_reg <= '0;
            busy_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            kind_reg   <= kind_next;
            cnt_reg    <= cnt_next;
            ans_reg    <= ans_next;
            nv_cmd_reg <= nv_cmd_next;
            busy_reg   <= (state_next == dsa_pkg::ST_WAIT);
        end
    end

    // Nonvolatile write timer: no reset branch so a write in flight ends
    // on its own; an unknown start value falls to the idle branch.
    always_comb begin
        // [R9] countdown continues through reset
        if (nv_cnt_reg != '0) begin
            nv_cnt_next = nv_cnt_reg - NW'(1);
        end else if (nv_start && !sys_rst_in) begin
            nv_cnt_next = NW'(NV_WRITE_CYCLES);
        end else begin
            nv_cnt_next = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        nv_cnt_reg  <= nv_cnt_next;
        nv_busy_reg <= (nv_cnt_next != '0);
    end

    assign ans_out           = ans_reg;
    assign busy_out          = busy_reg;
    assign nv_cmd_out        = nv_cmd_reg;
    assign nv_write_busy_out = nv_busy_reg;

    sequence sram_done_s;
        busy_out ##1 (ans_out.done && !busy_out);
    endsequence

    sequence nv_read_done_s;
        busy_out [*4] ##1 (ans_out.done && !busy_out);
    endsequence

    sram_time_a: assert property (  // [R7]
        @(posedge clk_in) disable iff (sys_rst_in)
        accept && in_sram && !is_io && is_read |=> sram_done_s)
        else $error("SRAM access not answered in two cycles");

    nv_read_halt_a: assert property (  // [R8]
        @(posedge clk_in) disable iff (sys_rst_in)
        accept && req_in.op == dsa_pkg::OP_NV_READ |=> nv_read_done_s)
        else $error("Nonvolatile read halt is not four cycles");

    nv_write_halt_a: assert property (  // [R8]
        @(posedge clk_in) disable iff (sys_rst_in)
        accept && req_in.op == dsa_pkg::OP_NV_WRITE
        |=> busy_out [*2] ##1 (ans_out.done && !busy_out))
        else $error("Nonvolatile write halt is not two cycles");

    nv_survive_a: assert property (  // [R9]
        @(posedge clk_in)
        sys_rst_in && nv_cnt_reg > NW'(1) |=> nv_write_busy_out)
        else $error("Reset aborted a nonvolatile write");

    bit_range_a: assert property (  // [R11]
        @(posedge clk_in) disable iff (sys_rst_in)
        accept && is_bit && !bit_ok |-> !wr_en ##1 !ans_out.skip)
        else $error("Bit access outside the low I/O range acted");

    bit_only_a: assert property (  // [R13]
        @(posedge clk_in) disable iff (sys_rst_in)
        accept && req_in.op == dsa_pkg::OP_IO_BIT_SET &&
        eff == dsa_pkg::GS0_ADDR
        |=> gs_reg[0] == ($past(gs_reg[0]) | $past(bit_mask)))
        else $error("Bit set changed other bits");

    flag_set_wins_a: assert property (  // [R14]
        @(posedge clk_in) disable iff (sys_rst_in)
        flag_event_in != 8'h00
        |=> (flag_reg & $past(flag_event_in)) == $past(flag_event_in))
        else $error("Flag set lost against a clear");

    low_write_a: assert property (  // [R18]
        @(posedge clk_in) disable iff (sys_rst_in)
        wr_en && eff == dsa_pkg::WORD_LO_ADDR && wr_mask == 8'hFF
        |=> $stable(word_reg) && temp_reg == $past(wr_data))
        else $error("Low byte write reached the word register");

    hi_read_a: assert property (  // [R19]
        @(posedge clk_in) disable iff (sys_rst_in)
        accept && is_read && eff == dsa_pkg::WORD_HI_ADDR
        |=> ans_out.rdata == $past(temp_reg))
        else $error("High byte read did not return the capture");

    io_window_a: assert property (  // [R2]
        @(posedge clk_in) disable iff (sys_rst_in)
        accept && is_io |-> eff < dsa_pkg::EXT_BASE)
        else $error("I/O instruction reached extended I/O");

    post_inc_a: assert property (  // [R6]
        @(posedge clk_in) disable iff (sys_rst_in)
        ptr_upd && req_in.mode == dsa_pkg::MODE_POST_INC
        |=> {rf_reg[5'($past(pidx) + 5'h01)], rf_reg[$past(pidx)]} ==
            $past(base) + 16'h0001)
        else $error("Post-increment pointer not written back");
endmodule

/* File: testbench/nv_model.sv */
// Purpose: Byte array standing in for the nonvolatile memory.
// Assumes: Only the low four address bits are decoded.
// Notes:   Before the first read and after each write command the byte toggles so stale data never matches.
`timescale 1ns/1ps
module nv_model (
    input  wire logic             clk_in,   // Core clock
    input  wire dsa_pkg::nv_cmd_t cmd_in,   // Unit command
    output logic      [7:0]       rdata_out // Read byte
);
    logic [7:0] mem [16];
    logic [3:0] ra_reg = 4'h0;
    logic       rd_reg = 1'b0;
    logic       tog_reg = 1'b0;
    always @(posedge clk_in) begin
        tog_reg <= ~tog_reg;
        if (cmd_in.strobe) begin
            rd_reg <= ~cmd_in.write;
            ra_reg <= cmd_in.addr[3:0];
        end
        if (cmd_in.strobe && cmd_in.write) begin
            mem[cmd_in.addr[3:0]] <= cmd_in.wdata;
        end
    end
    assign rdata_out = rd_reg ? mem[ra_reg] : {8{tog_reg}};
endmodule

/* File: testbench/data_space_access_unit_test.sv */
// Purpose: Self-checking bench for the access unit.
// Assumes: Nonvolatile write timer of 20 cycles.
// Notes:   Valid stands one cycle.
`timescale 1ns/1ps
module data_space_access_unit_test;
    logic             clk_in = 1'b0;
    logic             sys_rst_in = 1'b1;
    dsa_pkg::req_t    req = '0;
    logic [7:0]       flag_ev = 8'h00;
    logic [7:0]       nv_rd;
    dsa_pkg::ans_t    ans;
    dsa_pkg::nv_cmd_t nv_cmd;
    logic             nv_busy;
    int               err_count = 0;
    int               check_count = 0;
    always #50 clk_in = ~clk_in;
    data_space_access_unit #(.SRAM_DEPTH(1024), .NV_WRITE_CYCLES(20))
        u_data_space_access_unit (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .req_in(req), .flag_event_in(flag_ev), .nv_rdata_in(nv_rd),
        .ans_out(ans), .busy_out(), .nv_cmd_out(nv_cmd),
        .nv_write_busy_out(nv_busy));
    nv_model u_nv_model (.clk_in(clk_in), .cmd_in(nv_cmd), .rdata_out(nv_rd));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic go(input dsa_pkg::op_t op, input dsa_pkg::mode_t md,
        input dsa_pkg::ptr_t p, input logic [15:0] a, input logic [5:0] ds,
        input logic [7:0] d, input logic [2:0] b, input int n,
        input logic [7:0] rd, input logic sk);
        int k;
        k = 0;
        @(posedge clk_in);
        req <= '{1'b1, op, md, p, a, ds, b, d};
        do begin
            @(posedge clk_in);
            req.valid <= 1'b0;
            #1;
            k++;
        end while (ans.done !== 1'b1 && k < 20);
        chk(16'(k), 16'(n));
        if (op inside {dsa_pkg::OP_LOAD, dsa_pkg::OP_IN, dsa_pkg::OP_NV_READ})
            chk({8'h00, ans.rdata}, {8'h00, rd});
        chk({15'h0000, ans.skip}, {15'h0000, sk});
        if (k >= 20) tally_and_finish();
    endtask
    task automatic io(input dsa_pkg::op_t op, input logic [15:0] a,
        input logic [7:0] d, input logic [2:0] b, input logic sk);
        go(op, dsa_pkg::MODE_DIRECT, dsa_pkg::PTR_X, a, 6'h00, d, b, 1, d,
           sk);
    endtask
    task automatic st(input logic [15:0] a, input logic [7:0] d, input int n);
        go(dsa_pkg::OP_STORE, dsa_pkg::MODE_DIRECT, dsa_pkg::PTR_X, a, 6'h00,
           d, 3'h0, n, 8'h00, 1'b0);
    endtask
    task automatic ld(input logic [15:0] a, input logic [7:0] r, input int n);
        go(dsa_pkg::OP_LOAD, dsa_pkg::MODE_DIRECT, dsa_pkg::PTR_X, a, 6'h00,
           8'h00, 3'h0, n, r, 1'b0);
    endtask
    task automatic wait_nv;
        int k;
        k = 0;
        while (nv_busy !== 1'b0 && k < 40) begin
            @(posedge clk_in);
            #1;
            k++;
        end
        chk({15'h0000, nv_busy}, 16'h0000);
        if (k >= 40) tally_and_finish();
    endtask
    task automatic t_mem;
        st(16'h0100, 8'h5A, 2);
        ld(16'h0100, 8'h5A, 2);
        st(16'h001C, 8'h00, 1);
        st(16'h001D, 8'h01, 1);
        st(16'h013F, 8'h3C, 2);
        go(dsa_pkg::OP_LOAD, dsa_pkg::MODE_DISPLACED, dsa_pkg::PTR_Y, 16'h0000,
           6'h3F, 8'h00, 3'h0, 2, 8'h3C, 1'b0);
        go(dsa_pkg::OP_LOAD, dsa_pkg::MODE_POST_INC, dsa_pkg::PTR_Y, 16'h0000,
           6'h00, 8'h00, 3'h0, 2, 8'h5A, 1'b0);
        go(dsa_pkg::OP_LOAD, dsa_pkg::MODE_PRE_DEC, dsa_pkg::PTR_Y, 16'h0000,
           6'h00, 8'h00, 3'h0, 2, 8'h5A, 1'b0);
        ld(16'h001C, 8'h00, 1);
    endtask
    task automatic t_bits;
        io(dsa_pkg::OP_OUT, 16'h001E, 8'hA5, 3'h0, 1'b0);
        ld(16'h003E, 8'hA5, 1);
        io(dsa_pkg::OP_IO_BIT_CLEAR, 16'h001E, 8'h00, 3'h0, 1'b0);
        ld(16'h003E, 8'hA4, 1);
        io(dsa_pkg::OP_IO_BIT_SET, 16'h001E, 8'h00, 3'h6, 1'b0);
        io(dsa_pkg::OP_SKIP_IF_IO_BIT_SET, 16'h001E, 8'h00, 3'h6,
           1'b1);
        io(dsa_pkg::OP_SKIP_IF_IO_BIT_CLEAR, 16'h001E, 8'h00, 3'h0,
           1'b1);
        st(16'h004A, 8'hF0, 1);
        io(dsa_pkg::OP_IO_BIT_CLEAR, 16'h002A, 8'h00, 3'h4, 1'b0);
        ld(16'h004A, 8'hF0, 1);
        io(dsa_pkg::OP_SKIP_IF_IO_BIT_SET, 16'h002A, 8'h00, 3'h4,
           1'b0);
    endtask
    task automatic t_flag;
        @(posedge clk_in);
        flag_ev <= 8'h04;
        io(dsa_pkg::OP_IO_BIT_SET, 16'h0015, 8'h00, 3'h2, 1'b0);
        @(posedge clk_in);
        flag_ev <= 8'h00;
        io(dsa_pkg::OP_IN, 16'h0015, 8'h04, 3'h0, 1'b0);
        st(16'h0035, 8'h00, 1);
        ld(16'h0035, 8'h04, 1);
        io(dsa_pkg::OP_IO_BIT_SET, 16'h0015, 8'h00, 3'h2, 1'b0);
        ld(16'h0035, 8'h00, 1);
    endtask
    task automatic t_word;
        st(16'h0084, 8'h11, 1);
        ld(16'h0086, 8'h11, 1);
        st(16'h0085, 8'h22, 1);
        ld(16'h0084, 8'h11, 1);
        ld(16'h0085, 8'h22, 1);
        st(16'h0086, 8'h99, 1);
        ld(16'h0085, 8'h99, 1);
        st(16'h0600, 8'hFF, 1);
        ld(16'h0600, 8'h00, 1);
    endtask
    task automatic t_nv;
        go(dsa_pkg::OP_NV_WRITE, dsa_pkg::MODE_DIRECT, dsa_pkg::PTR_X,
           16'h0003, 6'h00, 8'h77, 3'h0, 3, 8'h00, 1'b0);
        wait_nv();
        go(dsa_pkg::OP_NV_READ, dsa_pkg::MODE_DIRECT, dsa_pkg::PTR_X, 16'h0003,
           6'h00, 8'h00, 3'h0, 5, 8'h77, 1'b0);
        go(dsa_pkg::OP_NV_WRITE, dsa_pkg::MODE_DIRECT, dsa_pkg::PTR_X,
           16'h0005, 6'h00, 8'h66, 3'h0, 3, 8'h00, 1'b0);
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        @(posedge clk_in);
        sys_rst_in <= 1'b0;
        #1;
        chk({15'h0000, nv_busy}, 16'h0001);
        wait_nv();
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_mem();
        t_bits();
        t_flag();
        t_word();
        t_nv();
        tally_and_finish();
    end
endmodule
